//--- design/maoe_map.svh
// Encodings, field positions and reset values for the four-instruction executer
`ifndef MAOE_MAP_SVH
`define MAOE_MAP_SVH

`define MAOE_OP_MSB       13
`define MAOE_OP_LSB       8
`define MAOE_D_BIT        7
`define MAOE_F_MSB        6
`define MAOE_F_LSB        0
`define MAOE_K_MSB        7
`define MAOE_K_LSB        0
`define MAOE_LIT_MSB      13
`define MAOE_LIT_LSB      10
`define MAOE_OP_OR        6'h04
`define MAOE_OP_COPY      6'h08
`define MAOE_OP_STORE     6'h00
`define MAOE_LIT_PATTERN  4'hC
`define MAOE_ACC_RESET    8'h00
`define MAOE_ZERO_BYTE    8'h00

`endif

//--- design/maoe_pkg.sv
// Types shared by the instruction executer
package maoe_pkg;
	typedef logic [13:0] maoe_instr_t;
	typedef logic [7:0]  maoe_byte_t;
	typedef logic [6:0]  maoe_addr_t;
	typedef enum logic [4:0] {
		MAOE_NONE  = 5'h01,
		MAOE_LOADK = 5'h02,
		MAOE_OR    = 5'h04,
		MAOE_COPY  = 5'h08,
		MAOE_STORE = 5'h10
	} maoe_kind_e;
endpackage

//--- design/maoe_exec.sv
// Decode and one-cycle execute of load-immediate, OR, copy and store instructions
`timescale 1ns/1ps
`include "maoe_map.svh"

// Behaviour
// - OR instruction ORs accumulator with addressed file register.
// - OR result goes to accumulator when d is 0, file register when 1.
// - Copy moves file register to accumulator (d=0) or itself (d=1).
// - Copy updates zero flag from moved value.
// - Store writes accumulator into addressed file register; accumulator kept.
module maoe_exec (
	input  wire logic                  mclk,      // Core clock
	input  wire logic                  reset,     // Async reset, active high
	input  wire logic                  instr_vld, // Instruction cycle enable
	input  wire maoe_pkg::maoe_instr_t instr,     // 14-bit instruction word
	input  wire maoe_pkg::maoe_byte_t  f_rdata,   // Value of addressed register
	output maoe_pkg::maoe_addr_t       f_addr,    // Register address
	output maoe_pkg::maoe_byte_t       f_wdata,   // Register write data
	output logic                       f_we,      // Register write pulse
	output maoe_pkg::maoe_byte_t       acc,       // Accumulator
	output logic                       zero_flag, // Zero flag
	output logic                       zero_we    // Zero flag update pulse
);
	import maoe_pkg::*;

	// ==========================================
	// Decode
	function automatic maoe_kind_e decode(input maoe_instr_t i);
		// Literal pattern goes first; its two low opcode bits are don't-care
		if (i[`MAOE_LIT_MSB:`MAOE_LIT_LSB] == `MAOE_LIT_PATTERN) begin
			decode = MAOE_LOADK;
		end else if (i[`MAOE_OP_MSB:`MAOE_OP_LSB] == `MAOE_OP_OR) begin
			decode = MAOE_OR;
		end else if (i[`MAOE_OP_MSB:`MAOE_OP_LSB] == `MAOE_OP_COPY) begin
			decode = MAOE_COPY;
		end else if (i[`MAOE_OP_MSB:`MAOE_OP_LSB] == `MAOE_OP_STORE && i[`MAOE_D_BIT]) begin
			decode = MAOE_STORE;
		end else begin
			decode = MAOE_NONE;
		end
	endfunction

	maoe_kind_e kind;
	logic       dbit;
	maoe_byte_t result;

	// ==========================================
	// Execute
	maoe_addr_t f_addr_r, f_addr_nxt;
	maoe_byte_t f_wdata_r, f_wdata_nxt, acc_r, acc_nxt;
	logic       f_we_r, f_we_nxt, zero_r, zero_nxt, zero_we_r, zero_we_nxt;

	always_comb begin
		kind = instr_vld ? decode(instr) : MAOE_NONE;
		dbit = instr[`MAOE_D_BIT];
		// Address tracks the word every cycle; it only matters while f_we stands
		f_addr_nxt = instr[`MAOE_F_MSB:`MAOE_F_LSB];
		f_wdata_nxt = f_wdata_r;
		f_we_nxt = 1'b0;
		acc_nxt = acc_r;
		zero_nxt = zero_r;
		zero_we_nxt = 1'b0;
		// Result defaults to the OR so that copy only swaps the operand
		result = acc_r | f_rdata;
		case (kind)
			MAOE_LOADK: begin
				acc_nxt = instr[`MAOE_K_MSB:`MAOE_K_LSB];
			end
			MAOE_OR, MAOE_COPY: begin
				if (kind == MAOE_COPY) begin
					result = f_rdata;
				end
				if (dbit) begin
					f_wdata_nxt = result;
					f_we_nxt = 1'b1;
				end else begin
					acc_nxt = result;
				end
				zero_nxt = (result == `MAOE_ZERO_BYTE);
				zero_we_nxt = 1'b1;
			end
			MAOE_STORE: begin
				f_wdata_nxt = acc_r;
				f_we_nxt = 1'b1;
			end
			default: begin
			end
		endcase
	end

	// Idle reset values keep the register file from seeing a stray write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			f_addr_r  <= '0;
			f_wdata_r <= `MAOE_ZERO_BYTE;
			f_we_r    <= 1'b0;
			acc_r     <= `MAOE_ACC_RESET;
			zero_r    <= 1'b0;
			zero_we_r <= 1'b0;
		end else begin
			f_addr_r  <= f_addr_nxt;
			f_wdata_r <= f_wdata_nxt;
			f_we_r    <= f_we_nxt;
			acc_r     <= acc_nxt;
			zero_r    <= zero_nxt;
			zero_we_r <= zero_we_nxt;
		end
	end

	// Write-back is registered: the register file sees address, data and strobe together
	assign f_addr    = f_addr_r;
	assign f_wdata   = f_wdata_r;
	assign f_we      = f_we_r;
	assign acc       = acc_r;
	assign zero_flag = zero_r;
	assign zero_we   = zero_we_r;

	// ==========================================
	// Assertions
	sequence s_or_to_reg;
		instr_vld && decode(instr) == MAOE_OR && instr[`MAOE_D_BIT];
	endsequence

	a_or_result: assert property (@(posedge mclk) disable iff (reset)
		instr_vld && decode(instr) == MAOE_OR && !instr[`MAOE_D_BIT]
		|=> acc == ($past(acc) | $past(f_rdata)))
		else $error("OR result wrong in accumulator");
	a_or_dest_reg: assert property (@(posedge mclk) disable iff (reset)
		s_or_to_reg |=> f_we && acc == $past(acc) && f_wdata == ($past(acc) | $past(f_rdata)))
		else $error("OR to register misrouted");
	a_copy_dest: assert property (@(posedge mclk) disable iff (reset)
		instr_vld && decode(instr) == MAOE_COPY
		|=> (f_we ? f_wdata : acc) == $past(f_rdata))
		else $error("Copy moved wrong value");
	a_copy_zero: assert property (@(posedge mclk) disable iff (reset)
		instr_vld && decode(instr) == MAOE_COPY
		|=> zero_we && zero_flag == ($past(f_rdata) == `MAOE_ZERO_BYTE))
		else $error("Copy zero flag wrong");
	a_store_write: assert property (@(posedge mclk) disable iff (reset)
		instr_vld && decode(instr) == MAOE_STORE
		|=> f_we && f_wdata == $past(acc) && acc == $past(acc)
		&& f_addr == $past(instr[`MAOE_F_MSB:`MAOE_F_LSB]))
		else $error("Store did not write accumulator");
	a_load_imm: assert property (@(posedge mclk) disable iff (reset)
		instr_vld && decode(instr) == MAOE_LOADK
		|=> acc == $past(instr[`MAOE_K_MSB:`MAOE_K_LSB]) && !zero_we && $stable(zero_flag) && !f_we)
		else $error("Load immediate wrong");
	a_idle_quiet: assert property (@(posedge mclk) disable iff (reset)
		!instr_vld |=> !f_we && !zero_we && $stable(acc))
		else $error("Activity without instruction");
	a_zero_hold: assert property (@(posedge mclk) disable iff (reset)
		!zero_we |-> $stable(zero_flag))
		else $error("Zero flag changed without update");

	// Raw-field sequences bypass decode(), so a broken decoder cannot hide behind them
	sequence s_raw_load;
		instr_vld && instr[`MAOE_LIT_MSB:`MAOE_LIT_LSB] == `MAOE_LIT_PATTERN;
	endsequence

	sequence s_raw_or;
		instr_vld && instr[`MAOE_OP_MSB:`MAOE_OP_LSB] == `MAOE_OP_OR;
	endsequence

	// Store opcode with the select bit clear belongs to other instructions: no effect here
	sequence s_raw_store_d0;
		instr_vld && instr[`MAOE_OP_MSB:`MAOE_OP_LSB] == `MAOE_OP_STORE
		&& !instr[`MAOE_D_BIT];
	endsequence

	sequence s_or_to_acc;
		instr_vld && decode(instr) == MAOE_OR && !instr[`MAOE_D_BIT];
	endsequence

	sequence s_copy_to_acc;
		instr_vld && decode(instr) == MAOE_COPY && !instr[`MAOE_D_BIT];
	endsequence

	sequence s_copy_to_reg;
		instr_vld && decode(instr) == MAOE_COPY && instr[`MAOE_D_BIT];
	endsequence

	sequence s_store;
		instr_vld && decode(instr) == MAOE_STORE;
	endsequence

	// Routing and flag checks built from the sequences above
	a_or_zero: assert property (@(posedge mclk) disable iff (reset)
		s_raw_or
		|=> zero_we && zero_flag == (($past(acc) | $past(f_rdata)) == `MAOE_ZERO_BYTE))
		else $error("OR zero flag wrong");

	a_or_acc_route: assert property (@(posedge mclk) disable iff (reset)
		s_or_to_acc |=> !f_we)
		else $error("OR to accumulator wrote the register");

	a_or_reg_addr: assert property (@(posedge mclk) disable iff (reset)
		s_or_to_reg |=> f_addr == $past(instr[`MAOE_F_MSB:`MAOE_F_LSB]))
		else $error("OR write-back went to wrong address");

	a_copy_to_acc: assert property (@(posedge mclk) disable iff (reset)
		s_copy_to_acc |=> !f_we && acc == $past(f_rdata))
		else $error("Copy to accumulator misrouted");

	a_copy_to_reg: assert property (@(posedge mclk) disable iff (reset)
		s_copy_to_reg |=> f_we && f_wdata == $past(f_rdata) && acc == $past(acc)
		&& f_addr == $past(instr[`MAOE_F_MSB:`MAOE_F_LSB]))
		else $error("Copy to register misrouted");

	a_store_no_flag: assert property (@(posedge mclk) disable iff (reset)
		s_store |=> !zero_we && $stable(zero_flag))
		else $error("Store touched the zero flag");

	a_load_raw: assert property (@(posedge mclk) disable iff (reset)
		s_raw_load |=> acc == $past(instr[`MAOE_K_MSB:`MAOE_K_LSB]) && !f_we)
		else $error("Literal encoding not loaded");

	a_refused_quiet: assert property (@(posedge mclk) disable iff (reset)
		s_raw_store_d0 |=> !f_we && !zero_we && $stable(acc))
		else $error("Non-store word caused activity");

	a_we_needs_instr: assert property (@(posedge mclk) disable iff (reset)
		f_we |-> $past(instr_vld))
		else $error("Write pulse without instruction");

	a_zero_update_src: assert property (@(posedge mclk) disable iff (reset)
		zero_we |-> $past(instr_vld))
		else $error("Zero update without instruction");
endmodule

//--- tb/move_and_or_instr_exec_bench.sv
// Self-checking bench for the four-instruction executer
`timescale 1ns/1ps
module move_and_or_instr_exec_bench;
	import maoe_pkg::*;
	logic        mclk = 0;
	logic        reset = 1;
	logic        instr_vld = 0;
	maoe_instr_t instr = 14'h0000;
	maoe_byte_t  f_rdata = 8'h00;
	maoe_addr_t  f_addr;
	maoe_byte_t  f_wdata, acc;
	logic        f_we, zero_flag, zero_we;
	int          n_errors = 0;
	int          tests_run = 0;
	// ==========================================
	// Clock and device
	always #2.5 mclk = ~mclk;
	maoe_exec dut_u (.mclk(mclk), .reset(reset), .instr_vld(instr_vld), .instr(instr),
		.f_rdata(f_rdata), .f_addr(f_addr), .f_wdata(f_wdata), .f_we(f_we), .acc(acc),
		.zero_flag(zero_flag), .zero_we(zero_we));
	// ==========================================
	// Shared tasks
	// Results are checked one falling edge after the taking edge, while pulses still stand
	task issue(input maoe_instr_t i, input maoe_byte_t r);
		@(negedge mclk);
		instr = i;
		f_rdata = r;
		instr_vld = 1;
		@(negedge mclk);
		instr_vld = 0;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task t_load;
		issue(14'h335A, 8'hFF);
		chk("acc", 8'h5A, acc);
		chk("zero_we", 8'h00, {7'h00, zero_we});
		chk("f_we", 8'h00, {7'h00, f_we});
	endtask
	task t_or;
		issue(14'h3091, 8'h00);
		issue(14'h042A, 8'h13);
		chk("acc", 8'h93, acc);
		chk("f_we", 8'h00, {7'h00, f_we});
		chk("zero", 8'h02, {6'h00, zero_we, zero_flag});
		issue(14'h04AA, 8'h40);
		chk("f_wdata", 8'hD3, f_wdata);
		chk("f_addr", 8'h2A, {1'b0, f_addr});
		chk("acc", 8'h93, acc);
		chk("f_we", 8'h01, {7'h00, f_we});
		issue(14'h3000, 8'h00);
		issue(14'h042A, 8'h00);
		chk("zero", 8'h03, {6'h00, zero_we, zero_flag});
	endtask
	task t_copy;
		issue(14'h082A, 8'h00);
		chk("acc", 8'h00, acc);
		chk("zero", 8'h03, {6'h00, zero_we, zero_flag});
		issue(14'h08AA, 8'hA5);
		chk("f_wdata", 8'hA5, f_wdata);
		chk("f_addr", 8'h2A, {1'b0, f_addr});
		chk("acc", 8'h00, acc);
		chk("we_zero", 8'h06, {5'h00, f_we, zero_we, zero_flag});
	endtask
	task t_store;
		issue(14'h304F, 8'h00);
		issue(14'h00B1, 8'hFF);
		chk("f_wdata", 8'h4F, f_wdata);
		chk("f_addr", 8'h31, {1'b0, f_addr});
		chk("acc", 8'h4F, acc);
		chk("we", 8'h02, {6'h00, f_we, zero_we});
	endtask
	// Words outside the four kinds must raise no write or flag pulse and leave the accumulator alone
	task t_refuse;
		issue(14'h002A, 8'h55);
		chk("we", 8'h00, {6'h00, f_we, zero_we});
		chk("acc", 8'h4F, acc);
		issue(14'h0A2A, 8'h00);
		chk("we", 8'h00, {6'h00, f_we, zero_we});
		chk("acc", 8'h4F, acc);
	endtask
	// Two instructions on adjacent edges: the OR must see the freshly loaded accumulator
	task t_b2b;
		@(negedge mclk);
		instr = 14'h300F;
		instr_vld = 1;
		@(negedge mclk);
		instr = 14'h042A;
		f_rdata = 8'hF0;
		@(negedge mclk);
		instr_vld = 0;
		chk("acc", 8'hFF, acc);
		chk("zero", 8'h02, {6'h00, zero_we, zero_flag});
	endtask
	// Mid-run reset with every output but zero_we away from its idle value, then a load on the first edge
	task t_reset;
		issue(14'h08AA, 8'h00);
		issue(14'h00B1, 8'h00);
		chk("pre flags", 8'h05, {5'h00, f_we, zero_we, zero_flag});
		chk("pre f_wdata", 8'hFF, f_wdata);
		reset = 1;
		@(negedge mclk);
		chk("acc", 8'h00, acc);
		chk("flags", 8'h00, {5'h00, f_we, zero_we, zero_flag});
		chk("f_wdata", 8'h00, f_wdata);
		chk("f_addr", 8'h00, {1'b0, f_addr});
		reset = 0;
		instr = 14'h3012;
		instr_vld = 1;
		@(negedge mclk);
		instr_vld = 0;
		chk("acc", 8'h12, acc);
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		reset = 0;
		t_load();
		t_or();
		t_copy();
		t_store();
		t_refuse();
		t_b2b();
		t_reset();
		results();
	end
	// About 53 cycles of reset and work in all; over seven times that before giving up
	initial begin
		#2000;
		n_errors++;
		results();
	end
endmodule
